// ==== shared/sdhe_pkg.sv ====
package sdhe_pkg;
	// Register byte addresses
	localparam logic [7:0] ADDR_STATUS = 8'h30;
	localparam logic [7:0] ADDR_CLEAR = 8'h34;
	localparam logic [7:0] ADDR_ENABLE = 8'h38;
	localparam logic [7:0] ADDR_CTRL = 8'h3C;
	localparam int ADDR_W = 8;
	// Status field positions
	localparam int BIT_CMD = 0;
	localparam int BIT_XFER = 1;
	localparam int BIT_GAP = 2;
	localparam int BIT_DMA = 3;
	localparam int BIT_ERR = 15;
	localparam int ERR_DATA_TIMEOUT = 4;
	localparam logic [15:0] STATUS_MASK = 16'h800F;
	localparam logic [15:0] STATUS_RESET = 16'h0000;
	localparam logic [15:0] ENABLE_RESET = 16'h0000;
	// Control field positions
	localparam int CTRL_GAP_REQ = 0;
	localparam int CTRL_TUNING = 1;
	localparam int CTRL_DAT_RST = 2;
	localparam logic [1:0] CTRL_RESET = 2'h0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [2:0] SEL_NONE = 3'h0;
	localparam logic [2:0] SEL_STATUS = 3'h1;
	localparam logic [2:0] SEL_CLEAR = 3'h2;
	localparam logic [2:0] SEL_ENABLE = 3'h3;
	localparam logic [2:0] SEL_CTRL = 3'h4;

	// Card-bus activity, sampled on link clock edges
	typedef struct packed {
		logic dir_write;
		logic resp_auto;
		logic resp_end;
		logic card_busy;
		logic write_active;
		logic read_active;
		logic data_line_busy;
	} sdhe_link_type;

	typedef struct packed {
		logic dma_boundary_flag;
		logic gap_stop_flag;
		logic xfer_done_flag;
		logic cmd_done_flag;
	} sdhe_flags_type;
endpackage

// ==== core/sdhe_event_flags.sv ====
`timescale 1ns/1ps
module sdhe_event_flags (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic link_clk,
	input wire sdhe_pkg::sdhe_link_type link_in,
	input wire logic dma_boundary_hit,
	input wire logic [15:0] error_status,
	output logic gap_stop_request,
	output logic tuning_active,
	output logic data_reset_pulse,
	output logic irq
);
	logic lclk_s1_q, lclk_s2_q, lclk_prev_q;
	sdhe_pkg::sdhe_link_type link_s1_q, link_s2_q, link_prev_q;
	sdhe_pkg::sdhe_flags_type flags_q, flags_d, flags_set, flags_clr;
	logic [15:0] enable_q, status_view, wmask, wclr;
	logic [1:0] ctrl_q;
	logic dat_rst_q;
	logic link_rise, err_summary;
	logic aw_hold_q, w_hold_q, commit;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic [2:0] wsel, rsel;
	logic bvalid_q, rvalid_q;
	logic [1:0] bresp_q, rresp_q;
	logic [31:0] rdata_q, rvalue;

	function automatic logic [2:0] decode(input logic [7:0] a);
		unique case (a)
			sdhe_pkg::ADDR_STATUS: decode = sdhe_pkg::SEL_STATUS;
			sdhe_pkg::ADDR_CLEAR: decode = sdhe_pkg::SEL_CLEAR;
			sdhe_pkg::ADDR_ENABLE: decode = sdhe_pkg::SEL_ENABLE;
			sdhe_pkg::ADDR_CTRL: decode = sdhe_pkg::SEL_CTRL;
			default: decode = sdhe_pkg::SEL_NONE;
		endcase
	endfunction

	// Link clock and activity synchronisers
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			lclk_s1_q <= 1'b0;
			lclk_s2_q <= 1'b0;
			lclk_prev_q <= 1'b0;
			link_s1_q <= '0;
			link_s2_q <= '0;
		end else begin
			lclk_s1_q <= link_clk;
			lclk_s2_q <= lclk_s1_q;
			lclk_prev_q <= lclk_s2_q;
			link_s1_q <= link_in;
			link_s2_q <= link_s1_q;
		end
	end

	assign link_rise = lclk_s2_q & ~lclk_prev_q;

	// Activity as seen at the previous link edge
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			link_prev_q <= '0;
		end else if (link_rise) begin
			link_prev_q <= link_s2_q;
		end
	end

	// Event detection at link edges; DMA boundary taken on any sys_clk cycle
	always_comb begin
		flags_set = '0;
		flags_set.dma_boundary_flag = dma_boundary_hit;
		if (link_rise) begin
			if (ctrl_q[sdhe_pkg::CTRL_GAP_REQ]) begin
				if (!link_prev_q.dir_write) begin
					flags_set.gap_stop_flag = link_prev_q.data_line_busy
						& ~link_s2_q.data_line_busy;
				end else begin
					flags_set.gap_stop_flag = link_prev_q.write_active
						& ~link_s2_q.write_active;
				end
			end
			if (!ctrl_q[sdhe_pkg::CTRL_TUNING]) begin
				if (!link_prev_q.dir_write) begin
					flags_set.xfer_done_flag = link_prev_q.read_active
						& ~link_s2_q.read_active;
				end else begin
					flags_set.xfer_done_flag = link_prev_q.data_line_busy
						& ~link_s2_q.data_line_busy;
				end
				if (link_prev_q.card_busy && !link_s2_q.card_busy) begin
					flags_set.xfer_done_flag = 1'b1;
				end
			end
			flags_set.cmd_done_flag = ~link_prev_q.resp_end & link_s2_q.resp_end
				& ~link_s2_q.resp_auto;
		end
	end

	// Write-one-to-clear, byte lanes honoured
	assign wmask = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
	assign wclr = (commit && (wsel == sdhe_pkg::SEL_STATUS || wsel == sdhe_pkg::SEL_CLEAR))
		? (wdata_q[15:0] & wmask) : 16'h0000;
	assign flags_clr = sdhe_pkg::sdhe_flags_type'(wclr[3:0]);

	always_comb begin
		flags_d = (flags_q & ~flags_clr) | flags_set;
		if (dat_rst_q) begin
			flags_d.gap_stop_flag = 1'b0;
			flags_d.xfer_done_flag = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			flags_q <= '0;
		end else begin
			flags_q <= flags_d;
		end
	end

	// Data timeout yields to a completed transfer
	assign err_summary = |(error_status & ~({15'h0000, flags_q.xfer_done_flag}
		<< sdhe_pkg::ERR_DATA_TIMEOUT));
	assign status_view = {err_summary, 11'h000, flags_q};

	// Enable and control registers
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			enable_q <= sdhe_pkg::ENABLE_RESET;
		end else if (commit && wsel == sdhe_pkg::SEL_ENABLE) begin
			enable_q <= ((enable_q & ~wmask) | (wdata_q[15:0] & wmask))
				& sdhe_pkg::STATUS_MASK;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			ctrl_q <= sdhe_pkg::CTRL_RESET;
			dat_rst_q <= 1'b0;
		end else begin
			dat_rst_q <= commit && wsel == sdhe_pkg::SEL_CTRL && wstrb_q[0]
				&& wdata_q[sdhe_pkg::CTRL_DAT_RST];
			if (dat_rst_q) begin
				ctrl_q[sdhe_pkg::CTRL_GAP_REQ] <= 1'b0;
			end else if (commit && wsel == sdhe_pkg::SEL_CTRL && wstrb_q[0]) begin
				ctrl_q <= wdata_q[1:0];
			end
		end
	end

	assign gap_stop_request = ctrl_q[sdhe_pkg::CTRL_GAP_REQ];
	assign tuning_active = ctrl_q[sdhe_pkg::CTRL_TUNING];
	assign data_reset_pulse = dat_rst_q;
	assign irq = |(status_view & enable_q);

	// AXI4-Lite write channel
	assign s_axi_awready = ~aw_hold_q;
	assign s_axi_wready = ~w_hold_q;
	assign commit = aw_hold_q & w_hold_q & ~bvalid_q;
	assign wsel = decode(awaddr_q);

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			aw_hold_q <= 1'b0;
			awaddr_q <= 8'h00;
		end else if (s_axi_awvalid && !aw_hold_q) begin
			aw_hold_q <= 1'b1;
			awaddr_q <= s_axi_awaddr;
		end else if (commit) begin
			aw_hold_q <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			w_hold_q <= 1'b0;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
		end else if (s_axi_wvalid && !w_hold_q) begin
			w_hold_q <= 1'b1;
			wdata_q <= s_axi_wdata;
			wstrb_q <= s_axi_wstrb;
		end else if (commit) begin
			w_hold_q <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			bvalid_q <= 1'b0;
			bresp_q <= sdhe_pkg::RESP_OKAY;
		end else if (commit) begin
			bvalid_q <= 1'b1;
			bresp_q <= (wsel == sdhe_pkg::SEL_NONE) ? sdhe_pkg::RESP_SLVERR
				: sdhe_pkg::RESP_OKAY;
		end else if (s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;

	// AXI4-Lite read channel
	assign s_axi_arready = ~rvalid_q;
	assign rsel = decode(s_axi_araddr);

	always_comb begin
		rvalue = 32'h00000000;
		unique case (rsel)
			sdhe_pkg::SEL_STATUS: rvalue = {16'h0000, status_view};
			sdhe_pkg::SEL_ENABLE: rvalue = {16'h0000, enable_q};
			sdhe_pkg::SEL_CTRL: rvalue = {30'h00000000, ctrl_q};
			default: rvalue = 32'h00000000;
		endcase
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= sdhe_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && !rvalid_q) begin
			rvalid_q <= 1'b1;
			rdata_q <= rvalue;
			rresp_q <= (rsel == sdhe_pkg::SEL_NONE) ? sdhe_pkg::RESP_SLVERR
				: sdhe_pkg::RESP_OKAY;
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	// Checks
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!resetn);

	property p_dma_set;
		dma_boundary_hit |=> flags_q.dma_boundary_flag;
	endproperty
	a_dma_set: assert property (p_dma_set) else $error("dma flag not set");

	property p_gap_needs_req;
		$rose(flags_q.gap_stop_flag) |-> $past(ctrl_q[sdhe_pkg::CTRL_GAP_REQ]);
	endproperty
	a_gap_needs_req: assert property (p_gap_needs_req) else $error("gap without request");

	property p_gap_read;
		link_rise && ctrl_q[0] && !link_prev_q.dir_write && link_prev_q.data_line_busy
			&& !link_s2_q.data_line_busy && !dat_rst_q |=> flags_q.gap_stop_flag;
	endproperty
	a_gap_read: assert property (p_gap_read) else $error("read gap missed");

	property p_gap_write;
		link_rise && ctrl_q[0] && link_prev_q.dir_write && link_prev_q.write_active
			&& !link_s2_q.write_active && !dat_rst_q |=> flags_q.gap_stop_flag;
	endproperty
	a_gap_write: assert property (p_gap_write) else $error("write gap missed");

	property p_xfer_read;
		link_rise && !ctrl_q[1] && !link_prev_q.dir_write && link_prev_q.read_active
			&& !link_s2_q.read_active && !dat_rst_q |=> flags_q.xfer_done_flag;
	endproperty
	a_xfer_read: assert property (p_xfer_read) else $error("read done missed");

	property p_xfer_write;
		link_rise && !ctrl_q[1] && link_prev_q.dir_write && link_prev_q.data_line_busy
			&& !link_s2_q.data_line_busy && !dat_rst_q |=> flags_q.xfer_done_flag;
	endproperty
	a_xfer_write: assert property (p_xfer_write) else $error("write done missed");

	property p_xfer_busy;
		link_rise && !ctrl_q[1] && link_prev_q.card_busy && !link_s2_q.card_busy && !dat_rst_q
			|=> flags_q.xfer_done_flag;
	endproperty
	a_xfer_busy: assert property (p_xfer_busy) else $error("busy release missed");

	property p_timeout_yields;
		flags_q.xfer_done_flag && error_status == (16'h0001 << sdhe_pkg::ERR_DATA_TIMEOUT)
			|-> !status_view[sdhe_pkg::BIT_ERR];
	endproperty
	a_timeout_yields: assert property (p_timeout_yields) else $error("timeout not masked");

	property p_no_xfer_tuning;
		$rose(flags_q.xfer_done_flag) |-> !$past(ctrl_q[sdhe_pkg::CTRL_TUNING]);
	endproperty
	a_no_xfer_tuning: assert property (p_no_xfer_tuning) else $error("done during tuning");

	property p_cmd_auto;
		$rose(flags_q.cmd_done_flag) |-> $past(link_rise) && !$past(link_s2_q.resp_auto);
	endproperty
	a_cmd_auto: assert property (p_cmd_auto) else $error("bad command done");

	property p_err_summary;
		(error_status & ~(16'h0001 << sdhe_pkg::ERR_DATA_TIMEOUT)) != 16'h0000
			|-> status_view[sdhe_pkg::BIT_ERR];
	endproperty
	a_err_summary: assert property (p_err_summary) else $error("summary low");

	property p_dat_reset;
		dat_rst_q |=> !flags_q.gap_stop_flag && !flags_q.xfer_done_flag && !ctrl_q[0];
	endproperty
	a_dat_reset: assert property (p_dat_reset) else $error("data reset ignored");

	property p_w1c_hold;
		!commit && flags_q.cmd_done_flag |=> flags_q.cmd_done_flag;
	endproperty
	a_w1c_hold: assert property (p_w1c_hold) else $error("flag lost");

	property p_w1c_clear;
		commit && wclr[sdhe_pkg::BIT_CMD] && !flags_set.cmd_done_flag
			|=> !flags_q.cmd_done_flag && s_axi_bvalid;
	endproperty
	a_w1c_clear: assert property (p_w1c_clear) else $error("clear ignored");

	c_cmd: cover property ($rose(flags_q.cmd_done_flag));
	c_xfer: cover property ($rose(flags_q.xfer_done_flag));
	c_gap: cover property ($rose(flags_q.gap_stop_flag));
	c_irq: cover property ($rose(irq));
endmodule

// ==== sim/sdhe_card_model.sv ====
`timescale 1ns/1ps
module sdhe_card_model (
	output logic link_clk,
	output sdhe_pkg::sdhe_link_type link_in
);
	initial begin
		link_clk = 1'b0;
		link_in = '0;
	end
	// One frame: level set, then a single link clock pulse; clock idles low
	task automatic send(input logic [6:0] v);
		#1;
		link_in = sdhe_pkg::sdhe_link_type'(v);
		#14;
		link_clk = 1'b1;
		#32;
		link_clk = 1'b0;
		#17;
	endtask
endmodule

// ==== sim/sd_host_transfer_event_flags_test.sv ====
`timescale 1ns/1ps
module sd_host_transfer_event_flags_test;
	logic sys_clk, resetn, link_clk, irq, dma_boundary_hit;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic gap_stop_request, tuning_active, data_reset_pulse;
	int rst_pulses = 0;
	logic [15:0] error_status;
	sdhe_pkg::sdhe_link_type link_in;
	int num_errors = 0;
	int checks_done = 0;

	sdhe_event_flags sdhe_event_flags_inst (.sys_clk(sys_clk), .resetn(resetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .link_clk(link_clk),
		.link_in(link_in), .dma_boundary_hit(dma_boundary_hit), .error_status(error_status),
		.gap_stop_request(gap_stop_request), .tuning_active(tuning_active),
		.data_reset_pulse(data_reset_pulse), .irq(irq));
	sdhe_card_model sdhe_card_model_inst (.link_clk(link_clk), .link_in(link_in));

	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		if (data_reset_pulse === 1'b1) rst_pulses <= rst_pulses + 1;
	end

	// Address lies in the register map
	function automatic logic mapped(input logic [7:0] a);
		mapped = a == sdhe_pkg::ADDR_STATUS || a == sdhe_pkg::ADDR_CLEAR
			|| a == sdhe_pkg::ADDR_ENABLE || a == sdhe_pkg::ADDR_CTRL;
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [15:0] d);
		logic ha, hw, hb;
		hb = 1'b0;
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= {16'h0000, d};
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!hb) begin
			@(negedge sys_clk);
			ha = s_axi_awvalid && s_axi_awready;
			hw = s_axi_wvalid && s_axi_wready;
			hb = s_axi_bvalid && s_axi_bready;
			rsp = s_axi_bresp;
			@(posedge sys_clk);
			if (ha) s_axi_awvalid <= 1'b0;
			if (hw) s_axi_wvalid <= 1'b0;
			if (hb) s_axi_bready <= 1'b0;
		end
		if (mapped(a)) chk({30'h0, rsp}, {30'h0, sdhe_pkg::RESP_OKAY}, "write resp");
	endtask
	task automatic axi_rd(input logic [7:0] a);
		logic ha, hr;
		hr = 1'b0;
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!hr) begin
			@(negedge sys_clk);
			ha = s_axi_arvalid && s_axi_arready;
			hr = s_axi_rvalid && s_axi_rready;
			rd = s_axi_rdata;
			rsp = s_axi_rresp;
			@(posedge sys_clk);
			if (ha) s_axi_arvalid <= 1'b0;
			if (hr) s_axi_rready <= 1'b0;
		end
		if (mapped(a)) chk({30'h0, rsp}, {30'h0, sdhe_pkg::RESP_OKAY}, "read resp");
	endtask
	task automatic st(input logic [15:0] e, input string w);
		axi_rd(sdhe_pkg::ADDR_STATUS);
		chk(rd, {16'h0000, e}, w);
	endtask
	task automatic frames(input logic [6:0] a, input logic [6:0] b);
		sdhe_card_model_inst.send(a);
		sdhe_card_model_inst.send(b);
	endtask
	task automatic clr();
		axi_wr(sdhe_pkg::ADDR_CLEAR, 16'h000F);
	endtask

	task automatic t_regs();
		st(16'h0000, "status reset");
		axi_rd(sdhe_pkg::ADDR_ENABLE);
		chk(rd, 32'h0, "enable reset");
		axi_wr(sdhe_pkg::ADDR_ENABLE, 16'hFFFF);
		axi_rd(sdhe_pkg::ADDR_ENABLE);
		chk(rd, 32'h0000800F, "enable mask");
		axi_wr(sdhe_pkg::ADDR_ENABLE, 16'h0000);
		axi_rd(8'h40);
		chk({30'h0, rsp}, {30'h0, sdhe_pkg::RESP_SLVERR}, "unmapped read");
		axi_wr(8'h44, 16'h000F);
		chk({30'h0, rsp}, {30'h0, sdhe_pkg::RESP_SLVERR}, "unmapped write");
	endtask
	task automatic t_cmd();
		frames(7'h00, 7'h10);
		st(16'h0001, "cmd done");
		axi_wr(sdhe_pkg::ADDR_CLEAR, 16'h0000);
		st(16'h0001, "zero write holds");
		clr();
		frames(7'h20, 7'h30);
		st(16'h0000, "auto cmd ignored");
	endtask
	task automatic t_xfer();
		frames(7'h02, 7'h00);
		st(16'h0002, "read done");
		clr();
		frames(7'h41, 7'h40);
		st(16'h0002, "write done");
		clr();
		frames(7'h48, 7'h40);
		st(16'h0002, "busy release");
		clr();
		axi_wr(sdhe_pkg::ADDR_CTRL, 16'h0002);
		chk({31'h0, tuning_active}, 32'h1, "tuning out");
		frames(7'h02, 7'h00);
		st(16'h0000, "tuning blocks");
		axi_wr(sdhe_pkg::ADDR_CTRL, 16'h0000);
	endtask
	task automatic t_gap();
		int n0;
		frames(7'h01, 7'h00);
		st(16'h0000, "gap without request");
		axi_wr(sdhe_pkg::ADDR_CTRL, 16'h0001);
		chk({31'h0, gap_stop_request}, 32'h1, "gap request out");
		frames(7'h01, 7'h00);
		st(16'h0004, "read gap");
		clr();
		frames(7'h44, 7'h40);
		st(16'h0004, "write gap");
		frames(7'h41, 7'h40);
		st(16'h0006, "gap and done");
		n0 = rst_pulses;
		axi_wr(sdhe_pkg::ADDR_CTRL, 16'h0005);
		repeat (2) @(posedge sys_clk);
		chk(32'(rst_pulses - n0), 32'h1, "reset pulse");
		st(16'h0000, "data reset clears");
		axi_rd(sdhe_pkg::ADDR_CTRL);
		chk(rd, 32'h0, "request cleared");
	endtask
	task automatic t_dma_irq();
		axi_wr(sdhe_pkg::ADDR_ENABLE, 16'h0008);
		dma_boundary_hit <= 1'b1;
		@(posedge sys_clk);
		dma_boundary_hit <= 1'b0;
		repeat (2) @(posedge sys_clk);
		st(16'h0008, "dma flag");
		chk({31'h0, irq}, 32'h1, "irq on");
		axi_wr(sdhe_pkg::ADDR_ENABLE, 16'h0000);
		chk({31'h0, irq}, 32'h0, "irq masked");
		axi_wr(sdhe_pkg::ADDR_ENABLE, 16'h0008);
		clr();
		chk({31'h0, irq}, 32'h0, "irq cleared");
		axi_wr(sdhe_pkg::ADDR_ENABLE, 16'h0000);
	endtask
	task automatic t_err();
		error_status <= 16'h0001;
		st(16'h8000, "error summary");
		error_status <= 16'h0010;
		frames(7'h02, 7'h00);
		st(16'h0002, "done outranks timeout");
		clr();
		st(16'h8000, "timeout shows");
		error_status <= 16'h0000;
	endtask
	task automatic t_reset();
		frames(7'h00, 7'h10);
		st(16'h0001, "cmd before reset");
		resetn <= 1'b0;
		repeat (2) @(posedge sys_clk);
		resetn <= 1'b1;
		st(16'h0000, "reset clears flags");
	endtask

	task tally_and_finish;
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	initial begin
		#100000;
		num_errors++;
		tally_and_finish;
	end
	initial begin
		resetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_awaddr = '0;
		s_axi_araddr = '0;
		s_axi_wdata = '0;
		s_axi_wstrb = 4'hF;
		dma_boundary_hit = 1'b0;
		error_status = 16'h0000;
		repeat (4) @(posedge sys_clk);
		resetn <= 1'b1;
		t_regs();
		t_cmd();
		t_xfer();
		t_gap();
		t_dma_irq();
		t_err();
		t_reset();
		tally_and_finish;
	end
endmodule
